// >>> hdl/pscp_cfg.svh
/*
 * Constants of the phase shift control port: register offsets, field positions,
 * reset values and timing figures.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef PSCP_CFG_SVH
`define PSCP_CFG_SVH

// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define PSCP_ADDR_W          8
`define PSCP_OFS_CTRL        8'h00
`define PSCP_OFS_STATUS      8'h04
`define PSCP_OFS_SHIFT       8'h08
`define PSCP_OFS_ID          8'h0C

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define PSCP_CTRL_PIN_EN     0
`define PSCP_CTRL_RST        32'h0000_0000
`define PSCP_PHASE_W         6
`define PSCP_CHAIN_DEPTH     6
`define PSCP_ID_VALUE        32'h0000_5A01
`define PSCP_RESP_OKAY       2'h0
`define PSCP_RESP_SLVERR     2'h2

// ****************************************************************
// Timing
// ****************************************************************
`define PSCP_CLK_PERIOD_NS   8
`define PSCP_SCK_MIN_NS      100
`define PSCP_LES_MIN_NS      630

`endif

// >>> hdl/pscp_pkg.sv
/*
 * Types of the phase shift control port.
 * Assumes pscp_cfg.svh on the include path.
 */
`include "pscp_cfg.svh"

package pscp_pkg;

	// Control mode, one-hot
	typedef enum logic [1:0]
	{
		PSCP_MODE_PARALLEL = 2'b01,
		PSCP_MODE_SERIAL   = 2'b10
	} pscp_mode_t;

	// Read channel state, one-hot
	typedef enum logic [1:0]
	{
		PSCP_RD_IDLE = 2'b01,
		PSCP_RD_RESP = 2'b10
	} pscp_rd_t;

	typedef logic [`PSCP_PHASE_W-1:0] pscp_phase_t;

endpackage

// >>> hdl/pscp_sync.sv
/*
 * Two flip-flop synchroniser for a group of pin levels.
 * Assumes inputs asynchronous to clock_i; output is one clock later than usual.
 */
`timescale 1ns/1ns

module pscp_sync
#(
	parameter int WIDTH = 1
)
(
	input  wire logic             clock_i,
	input  wire logic             reset_n_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] stage_a;
	logic [WIDTH-1:0] stage_b;

	// First stage is read only by the second stage
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			stage_a <= '0;
			stage_b <= '0;
		end
		else
		begin
			stage_a <= async_i;
			stage_b <= stage_a;
		end
	end

	assign sync_o = stage_b;

endmodule

// >>> hdl/pscp_top.sv
/*
 * Phase shift control port: serial or direct parallel loading of a 6-bit phase
 * word, with daisy-chain output and an AXI4-Lite register view.
 * Assumes pins are asynchronous to clock_i and that the shift clock period is
 * well above four clock_i periods, so every shift clock edge is seen.
 */
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns

`include "pscp_cfg.svh"

// Behaviour
// - A high mode select pin puts the port in serial mode whatever the strobe does.
// - After six bits a rising strobe edge copies the shift word to the phase state.
// - Shift clock edges are ignored while the strobe is high.
// - The chained output is the serial input delayed by six shift clock cycles.
// - A low mode select pin disables the serial interface entirely.
// - In serial mode the shared pins act as strobe, shift clock and serial data.
// - In serial mode the phase state holds while the strobe stays low.
// - In parallel mode the phase state follows the six phase bit inputs directly.
// - In parallel mode the shared pins act as phase bits 3, 2 and 1.
// - The phase word is binary weighted with phase bit 1 as the 5.6 degree step.
module pscp_top
	import pscp_pkg::*;
(
	input  wire logic        clock_i,
	input  wire logic        reset_n_i,
	// Pins
	input  wire logic        serial_parallel_select_i,
	input  wire logic        phase_bit_6_i,
	input  wire logic        phase_bit_5_i,
	input  wire logic        phase_bit_4_i,
	input  wire logic        shared_pin_3_i,
	input  wire logic        shared_pin_2_i,
	input  wire logic        shared_pin_1_i,
	output logic             chained_data_out_o,
	output logic [5:0]       phase_state_o,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	// ****************************************************************
	// Pin synchronisation
	// ****************************************************************
	logic [6:0] pins_sync;

	pscp_sync #(.WIDTH(7)) u_sync
	(
		.clock_i   (clock_i),
		.reset_n_i (reset_n_i),
		.async_i   ({serial_parallel_select_i, phase_bit_6_i, phase_bit_5_i,
		              phase_bit_4_i, shared_pin_3_i, shared_pin_2_i, shared_pin_1_i}),
		.sync_o    (pins_sync)
	);

	logic mode_sel;
	logic pin3;
	logic pin2;
	logic pin1;
	assign mode_sel = pins_sync[6];
	assign pin3     = pins_sync[2];
	assign pin2     = pins_sync[1];
	assign pin1     = pins_sync[0];

	pscp_mode_t mode;
	assign mode = mode_sel ? PSCP_MODE_SERIAL : PSCP_MODE_PARALLEL;

	// Shared pin roles in serial mode
	logic strobe;
	logic sck;
	logic sdi;
	assign strobe = pin3;
	assign sck    = pin2;
	assign sdi    = pin1;

	// ****************************************************************
	// Serial engine
	// ****************************************************************
	logic        sck_d;
	logic        strobe_d;
	logic [5:0]  shift_word;
	logic [5:0]  chain;
	logic [5:0]  phase;
	logic        pins_enable;
	logic [5:0]  next_shift_word;
	logic [5:0]  next_chain;
	logic [5:0]  next_phase;
	logic        shift_edge;
	logic        commit_edge;

	// Edges only count in serial mode; a high strobe masks the shift clock
	assign shift_edge  = (mode == PSCP_MODE_SERIAL) && sck && !sck_d && !strobe;
	assign commit_edge = (mode == PSCP_MODE_SERIAL) && strobe && !strobe_d;

	// Next shift, chain and phase values
	always_comb
	begin
		next_shift_word = shift_word;
		next_chain      = chain;
		next_phase      = phase;
		if (shift_edge)
		begin
			next_shift_word = {shift_word[4:0], sdi}; // MSB ends at bit 5
			next_chain      = {chain[4:0], sdi};
		end
		if (!pins_enable)
			next_phase = phase;
		else if (mode == PSCP_MODE_PARALLEL)
			next_phase = {pins_sync[5:3], pin3, pin2, pin1};
		else if (commit_edge)
			next_phase = shift_word;
	end

	// Register serial state; edge memories track pins in every mode
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			sck_d      <= 1'b0;
			strobe_d   <= 1'b0;
			shift_word <= '0;
			chain      <= '0;
			phase      <= '0;
		end
		else
		begin
			sck_d      <= sck;
			strobe_d   <= strobe;
			shift_word <= next_shift_word;
			chain      <= next_chain;
			phase      <= next_phase;
		end
	end

	assign chained_data_out_o = chain[`PSCP_CHAIN_DEPTH-1];
	assign phase_state_o      = phase;

	// ****************************************************************
	// AXI4-Lite write channel
	// ****************************************************************
	logic        aw_held;
	logic [7:0]  aw_addr;
	logic        w_held;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        bvalid;
	logic [1:0]  bresp;
	logic        next_aw_held;
	logic [7:0]  next_aw_addr;
	logic        next_w_held;
	logic [31:0] next_w_data;
	logic [3:0]  next_w_strb;
	logic        next_bvalid;
	logic [1:0]  next_bresp;
	logic        next_pins_enable;
	logic        do_write;

	assign s_axi_awready = !aw_held && !bvalid;
	assign s_axi_wready  = !w_held && !bvalid;
	assign do_write      = aw_held && w_held && !bvalid;

	// Address and data are latched independently, in either order
	always_comb
	begin
		next_aw_held     = aw_held;
		next_aw_addr     = aw_addr;
		next_w_held      = w_held;
		next_w_data      = w_data;
		next_w_strb      = w_strb;
		next_bvalid      = bvalid;
		next_bresp       = bresp;
		next_pins_enable = pins_enable;
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (do_write)
		begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = `PSCP_RESP_OKAY;
			if (aw_addr == `PSCP_OFS_CTRL)
			begin
				if (w_strb[0])
					next_pins_enable = w_data[`PSCP_CTRL_PIN_EN];
			end
			else if (aw_addr != `PSCP_OFS_STATUS && aw_addr != `PSCP_OFS_SHIFT
			         && aw_addr != `PSCP_OFS_ID)
				next_bresp = `PSCP_RESP_SLVERR;
		end
		if (bvalid && s_axi_bready)
			next_bvalid = 1'b0;
	end

	// Control enable resets low: phase state frozen until software enables pins
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			aw_held     <= 1'b0;
			aw_addr     <= '0;
			w_held      <= 1'b0;
			w_data      <= '0;
			w_strb      <= '0;
			bvalid      <= 1'b0;
			bresp       <= `PSCP_RESP_OKAY;
			pins_enable <= 1'b0;
		end
		else
		begin
			aw_held     <= next_aw_held;
			aw_addr     <= next_aw_addr;
			w_held      <= next_w_held;
			w_data      <= next_w_data;
			w_strb      <= next_w_strb;
			bvalid      <= next_bvalid;
			bresp       <= next_bresp;
			pins_enable <= next_pins_enable;
		end
	end

	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp  = bresp;

	// ****************************************************************
	// AXI4-Lite read channel
	// ****************************************************************
	pscp_rd_t    rd_state;
	pscp_rd_t    next_rd_state;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic [1:0]  rresp;
	logic [1:0]  next_rresp;

	assign s_axi_arready = (rd_state == PSCP_RD_IDLE);

	// Read data are captured at address acceptance
	always_comb
	begin
		next_rd_state = rd_state;
		next_rdata    = rdata;
		next_rresp    = rresp;
		case (rd_state)
			PSCP_RD_IDLE:
			begin
				if (s_axi_arvalid)
				begin
					next_rd_state = PSCP_RD_RESP;
					next_rresp    = `PSCP_RESP_OKAY;
					case (s_axi_araddr)
						`PSCP_OFS_CTRL:   next_rdata = {31'h0000_0000, pins_enable};
						`PSCP_OFS_STATUS: next_rdata = {24'h00_0000, mode_sel,
						                                chained_data_out_o, phase};
						`PSCP_OFS_SHIFT:  next_rdata = {26'h000_0000, shift_word};
						`PSCP_OFS_ID:     next_rdata = `PSCP_ID_VALUE;
						default:
						begin
							next_rdata = 32'h0000_0000;
							next_rresp = `PSCP_RESP_SLVERR;
						end
					endcase
				end
			end
			PSCP_RD_RESP:
			begin
				if (s_axi_rready)
					next_rd_state = PSCP_RD_IDLE;
			end
			default:
				next_rd_state = PSCP_RD_IDLE;
		endcase
	end

	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rd_state <= PSCP_RD_IDLE;
			rdata    <= '0;
			rresp    <= `PSCP_RESP_OKAY;
		end
		else
		begin
			rd_state <= next_rd_state;
			rdata    <= next_rdata;
			rresp    <= next_rresp;
		end
	end

	assign s_axi_rvalid = (rd_state == PSCP_RD_RESP);
	assign s_axi_rdata  = rdata;
	assign s_axi_rresp  = rresp;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	sequence s_commit;
		pins_enable && mode == PSCP_MODE_SERIAL && strobe && !strobe_d;
	endsequence

	a_commit_loads: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		s_commit |=> phase == $past(shift_word))
		else $error("Phase not loaded on commit");

	a_hold_low: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(mode == PSCP_MODE_SERIAL && !strobe) |=> $stable(phase))
		else $error("Phase changed while strobe low");

	a_mask_shift: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		strobe |=> $stable(shift_word))
		else $error("Shift word changed while strobe high");

	a_shift_msb: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		shift_edge |=> shift_word[0] == $past(sdi) && shift_word[5:1] == $past(shift_word[4:0]))
		else $error("Shift not MSB first");

	a_chain_out: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		shift_edge |=> chained_data_out_o == $past(chain[4]))
		else $error("Chain output wrong");

	a_serial_off: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(mode == PSCP_MODE_PARALLEL) |=> $stable(shift_word) && $stable(chain))
		else $error("Serial active in parallel mode");

	a_parallel_track: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(pins_enable && mode == PSCP_MODE_PARALLEL) |=> phase == $past(pins_sync[5:0]))
		else $error("Phase not following parallel pins");

	a_read_answer: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
		else $error("Read answer missing");

endmodule

// >>> sim/pscp_host.sv
/*
 * Host controller model: drives the mode pin and six phase pins.
 * Assumes tasks are called right after a rising edge of clock_i.
 */
`timescale 1ns/1ns

module pscp_host
(
	input  wire logic clock_i,
	output logic      select_o,
	output logic      phase_bit_6_o,
	output logic      phase_bit_5_o,
	output logic      phase_bit_4_o,
	output logic      shared_pin_3_o,
	output logic      shared_pin_2_o,
	output logic      shared_pin_1_o
);
	// ****************************************************************
	// Pin drive
	// ****************************************************************
	logic [5:0] pin = 6'h00;
	time        last_le = 0;

	// Bit 2 strobe, bit 1 shift clock, bit 0 data in serial mode
	assign {phase_bit_6_o, phase_bit_5_o, phase_bit_4_o} = pin[5:3];
	assign {shared_pin_3_o, shared_pin_2_o, shared_pin_1_o} = pin[2:0];

	initial
	begin
		select_o = 1'b0;
	end

	task tick(input int n);
		repeat (n) @(posedge clock_i);
	endtask

	// Static levels, no strobe or clock
	task set_par(input logic [5:0] w);
		select_o <= 1'b0;
		pin      <= w;
		tick(8);
	endtask

	task serial_mode;
		select_o <= 1'b1;
		pin      <= 6'h00;
		tick(8);
	endtask

	// Shift clock runs only inside a frame; data line is not held after
	task shift_bit(input logic b);
		pin[0] <= b;
		tick(4);
		pin[1] <= 1'b1;
		tick(5); // High 5 plus low 8 clocks keeps the period at 104 ns
		pin[1] <= 1'b0;
		pin[0] <= ~b;
		tick(4);
	endtask

	task shift_word(input logic [5:0] w);
		for (int i = 5; i >= 0; i--)
			shift_bit(w[i]);
	endtask

	// Strobe pulse; n clock pulses during it should be masked
	task commit(input int n);
		while ($time - last_le < 630)
			tick(1);
		pin[2] <= 1'b1;
		last_le = $time;
		tick(4);
		repeat (n)
		begin
			pin[1] <= 1'b1;
			pin[0] <= ~pin[0];
			tick(5);
			pin[1] <= 1'b0;
			tick(8); // Masked pulses still keep the minimum period
		end
		pin[2] <= 1'b0;
		tick(4);
	endtask
endmodule

// >>> sim/pscp_top_tb.sv
/*
 * Self-checking bench of the phase shift control port.
 * Assumes pscp_host drives the pins; registers reached over AXI4-Lite.
 */
`timescale 1ns/1ns
`include "pscp_cfg.svh"

module pscp_top_tb;
	// ****************************************************************
	// Signals and instances
	// ****************************************************************
	logic        clock_i, reset_n_i, sel, b6, b5, b4, p3, p2, p1, chain;
	logic [5:0]  phase;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	int          n_mismatch = 0;
	int          comparisons = 0;

	pscp_host u_pscp_host (.clock_i, .select_o(sel), .phase_bit_6_o(b6),
		.phase_bit_5_o(b5), .phase_bit_4_o(b4), .shared_pin_3_o(p3),
		.shared_pin_2_o(p2), .shared_pin_1_o(p1));

	pscp_top u_pscp_top (.clock_i, .reset_n_i, .serial_parallel_select_i(sel),
		.phase_bit_6_i(b6), .phase_bit_5_i(b5), .phase_bit_4_i(b4),
		.shared_pin_3_i(p3), .shared_pin_2_i(p2), .shared_pin_1_i(p1),
		.chained_data_out_o(chain), .phase_state_o(phase), .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Read right after a rising edge, readies and answers are the values sampled at it
	task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		bit aw, w, b;
		@(posedge clock_i);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_wstrb   <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do
		begin
			@(posedge clock_i);
			aw = s_axi_awvalid & s_axi_awready;
			w  = s_axi_wvalid & s_axi_wready;
			b  = s_axi_bvalid;
			rs = s_axi_bresp;
			if (aw)
				s_axi_awvalid <= 1'b0;
			if (w)
				s_axi_wvalid <= 1'b0;
			if (b)
				s_axi_bready <= 1'b0;
		end
		while (!b);
		chk("bresp", rs, er);
	endtask

	task axi_rd(input logic [7:0] a);
		bit ar, r;
		@(posedge clock_i);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do
		begin
			@(posedge clock_i);
			ar = s_axi_arvalid & s_axi_arready;
			r  = s_axi_rvalid;
			rd = s_axi_rdata;
			rs = s_axi_rresp;
			if (ar)
				s_axi_arvalid <= 1'b0;
			if (r)
				s_axi_rready <= 1'b0;
		end
		while (!r);
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task t_regs;
		axi_rd(`PSCP_OFS_ID);
		chk("id", rd, `PSCP_ID_VALUE);
		axi_rd(8'h10);
		chk("rresp", rs, `PSCP_RESP_SLVERR);
		chk("rdata", rd, 32'h0000_0000);
		axi_rd(`PSCP_OFS_CTRL);
		chk("ctrl", rd, `PSCP_CTRL_RST);
		// Pins held off until enabled
		u_pscp_host.set_par(6'h3F);
		chk("phase", phase, 32'h0000_0000);
		axi_wr(`PSCP_OFS_CTRL, 32'h0000_0001, 4'hF, `PSCP_RESP_OKAY);
		u_pscp_host.tick(4);
		chk("phase", phase, 32'h0000_003F);
		// Byte lane 0 off: the enable must not drop
		axi_wr(`PSCP_OFS_CTRL, 32'h0000_0000, 4'hE, `PSCP_RESP_OKAY);
		axi_rd(`PSCP_OFS_CTRL);
		chk("ctrl", rd, 32'h0000_0001);
		// Read-only offset ignores a write, unmapped offset refuses it
		axi_wr(`PSCP_OFS_ID, 32'h0000_0000, 4'hF, `PSCP_RESP_OKAY);
		axi_rd(`PSCP_OFS_ID);
		chk("id", rd, `PSCP_ID_VALUE);
		axi_wr(8'h10, 32'h0000_0000, 4'hF, `PSCP_RESP_SLVERR);
		$display("test regs done");
	endtask

	task t_parallel;
		for (int i = 0; i < 6; i++)
		begin
			u_pscp_host.set_par(6'h01 << i);
			chk("phase", phase, 32'h0000_0001 << i);
		end
		u_pscp_host.set_par(6'h00);
		chk("phase", phase, 32'h0000_0000);
		$display("test parallel done");
	endtask

	// Two words back to back: second one pushes the first out of the chain
	task t_serial;
		logic [5:0] a, b;
		a = 6'h32;
		b = 6'h1B;
		u_pscp_host.serial_mode;
		u_pscp_host.shift_word(a);
		// Chain output shows the bit taken six shift edges before
		for (int i = 5; i >= 0; i--)
		begin
			chk("chain", chain, a[i]);
			u_pscp_host.shift_bit(b[i]);
		end
		chk("chain", chain, b[5]);
		chk("phase", phase, 32'h0000_0000);
		u_pscp_host.commit(0);
		chk("phase", phase, b);
		axi_rd(`PSCP_OFS_STATUS);
		chk("status", rd, {24'h00_0000, 1'b1, b[5], b});
		$display("test serial done");
	endtask

	task t_mask;
		u_pscp_host.shift_word(6'h27);
		u_pscp_host.commit(3);
		chk("phase", phase, 32'h0000_0027);
		axi_rd(`PSCP_OFS_SHIFT);
		chk("shift", rd, 32'h0000_0027);
		u_pscp_host.commit(0);
		chk("phase", phase, 32'h0000_0027);
		$display("test mask done");
	endtask

	// Serial pattern on shared pins in parallel mode only moves the phase
	task t_disable;
		logic [31:0] s0;
		axi_rd(`PSCP_OFS_SHIFT);
		s0 = rd;
		u_pscp_host.set_par(6'h00);
		u_pscp_host.shift_word(6'h14);
		u_pscp_host.commit(0);
		u_pscp_host.tick(4);
		chk("phase", phase, 32'h0000_0001);
		axi_rd(`PSCP_OFS_SHIFT);
		chk("shift", rd, s0);
		chk("chain", chain, 1'b1);
		axi_rd(`PSCP_OFS_STATUS);
		chk("status", rd, {24'h00_0000, 1'b0, 1'b1, 6'h01});
		$display("test disable done");
	endtask

	// ****************************************************************
	// Clock, reset, sequence and verdict
	// ****************************************************************
	task complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end

	initial
	begin
		reset_n_i     = 1'b0;
		s_axi_awaddr  = 8'h00;
		s_axi_araddr  = 8'h00;
		s_axi_wdata   = 32'h0000_0000;
		s_axi_wstrb   = 4'hF;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid  = 1'b0;
		s_axi_bready  = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready  = 1'b0;
		repeat (2) @(posedge clock_i);
		reset_n_i <= 1'b1;
		t_regs;
		t_parallel;
		t_serial;
		t_mask;
		t_disable;
		complete_run;
	end

	// Tests take well under 10000 clocks
	initial
	begin
		#200000;
		n_mismatch++;
		complete_run;
	end
endmodule
